// ---- src/bwc_pkg.sv ----
// Constants, register map and state type for the burst waveform controller
package bwc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS       = 10;
  localparam int GAP_NS       = 200;
  localparam int GAP_CYC      = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int US_NS        = 1000;
  localparam int US_CYC       = US_NS / CLK_NS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_PERIOD  = 8'h0C;
  localparam logic [7:0] OFS_PHASE   = 8'h10;
  localparam logic [7:0] OFS_FREQ_LO = 8'h14;
  localparam logic [7:0] OFS_FREQ_HI = 8'h18;
  localparam logic [7:0] OFS_TRIG    = 8'h1C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_TYPE     = 0;
  localparam int CTL_ORIG_LO  = 1;
  localparam int CTL_LOW      = 3;
  localparam int CTL_SLOPE    = 4;
  localparam int CTL_UNB      = 5;
  localparam int CTL_SHAPE_LO = 8;
  localparam int ST_RUN       = 0;
  localparam int ST_ERR       = 1;
  localparam int ST_STRETCH   = 2;
  localparam int ST_GATE      = 3;
  localparam int ST_WAIT      = 4;
  localparam int PH_UNIT      = 17;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] ORIG_INT = 2'h0;
  localparam logic [1:0] ORIG_EXT = 2'h1;
  localparam logic [1:0] ORIG_BUS = 2'h2;
  localparam logic [1:0] ORIG_MAN = 2'h3;
  localparam logic [2:0] SHP_SINE = 3'h0;
  localparam logic [2:0] SHP_SQR  = 3'h1;
  localparam logic [2:0] SHP_RAMP = 3'h2;
  localparam logic [2:0] SHP_PULS = 3'h3;
  localparam logic [2:0] SHP_ARB  = 3'h4;
  localparam logic [2:0] SHP_NOIS = 3'h5;
  localparam logic [2:0] SHP_DC   = 3'h6;

  // ****************************************
  // Limits (frequency in mHz, period in us, phase in 0.01 degree)
  // ****************************************
  localparam logic [36:0] FREQ_MIN   = 37'h0_0000_0002;
  localparam logic [36:0] FREQ_MAX   = 37'h12_A05F_2000;
  localparam logic [36:0] FREQ_RAMP  = 37'h0_3B9A_CA00;
  localparam logic [36:0] FREQ_ARB   = 37'h5_D21D_BA00;
  localparam logic [19:0] COUNT_MAX  = 20'hF_4240;
  localparam logic [28:0] PERIOD_MIN = 29'h000_0001;
  localparam logic [28:0] PERIOD_MAX = 29'h1DCD_6500;
  localparam int          PHASE_LIM  = 36000;
  localparam logic [15:0] RAD2DEG    = 16'h5BAC;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [10:0] CTRL_RST   = 11'h000;
  localparam logic [19:0] COUNT_RST  = 20'h0_0001;
  localparam logic [28:0] PERIOD_RST = 29'h000_2710;
  localparam logic [36:0] FREQ_RST   = 37'h0_000F_4240;

  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_DRAIN} bwc_state_e;

endpackage

// ---- src/bwc_core.sv ----
// Burst sequencer with parameter checking and automatic period stretch
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module bwc_core
  import bwc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trigger or gate pin and panel key
  input  wire logic        trig_pin,
  input  wire logic        manual_trig,
  // Waveform synthesizer side
  input  wire logic        cycle_end,
  output logic             wave_run,
  output logic             phase_load,
  output logic signed [16:0] start_phase,
  output logic      [2:0]  wave_shape,
  output logic      [36:0] wave_freq
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [10:0] ctrl_r, ctrl_nxt;
  logic [19:0] count_r, count_nxt;
  logic [28:0] period_r, period_nxt;
  logic signed [16:0] phase_r, phase_nxt;
  logic [4:0]  fhi_r, fhi_nxt;
  logic [36:0] freq_r, freq_nxt;
  logic        err_r, err_nxt;
  logic        str_r, str_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        bus_trig;
  logic        str_set;

  logic        gated;
  logic [1:0]  origin;
  logic        low_sense;
  logic        slope_fall;
  logic        unbounded_count;
  logic [2:0]  shape;

  assign gated           = ctrl_r[CTL_TYPE];
  assign origin          = ctrl_r[CTL_ORIG_LO +: 2];
  assign low_sense       = ctrl_r[CTL_LOW];
  assign slope_fall      = ctrl_r[CTL_SLOPE];
  assign unbounded_count = ctrl_r[CTL_UNB];
  assign shape           = ctrl_r[CTL_SHAPE_LO +: 3];

  function automatic logic cfg_ok(input logic [2:0] shp, input logic gt,
                                  input logic unb, input logic [36:0] f);
    logic [36:0] lim;
    cfg_ok = 1'b1;
    lim    = FREQ_MAX;
    if (shp == SHP_RAMP) lim = FREQ_RAMP;
    if (shp == SHP_ARB) lim = FREQ_ARB;
    if (shp == SHP_DC || shp > SHP_DC) cfg_ok = 1'b0;
    if (shp == SHP_NOIS && !gt) cfg_ok = 1'b0;
    if (f < FREQ_MIN || f > lim) cfg_ok = 1'b0;
    if ((shp == SHP_SINE || shp == SHP_SQR) && f > FREQ_ARB && !unb) begin
      cfg_ok = 1'b0;
    end
  endfunction

  logic signed [32:0] ph_prod;
  logic signed [16:0] ph_deg;
  logic [36:0]        freq_cand;
  logic [2:0]         shp_w;

  always_comb begin
    ph_prod   = $signed(reg_wdata[16:0]) * $signed({1'b0, RAD2DEG});
    ph_deg    = reg_wdata[PH_UNIT] ? 17'(ph_prod >>> 12) : $signed(reg_wdata[16:0]);
    freq_cand = {fhi_r, reg_wdata};
    shp_w     = reg_wdata[CTL_SHAPE_LO +: 3];
  end

  logic [31:0] status_w;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    count_nxt  = count_r;
    period_nxt = period_r;
    phase_nxt  = phase_r;
    fhi_nxt    = fhi_r;
    freq_nxt   = freq_r;
    bus_trig   = 1'b0;
    err_nxt    = err_r;
    str_nxt    = str_r;
    rdata_nxt  = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          if (cfg_ok(shp_w, reg_wdata[CTL_TYPE], reg_wdata[CTL_UNB], freq_r)) begin
            ctrl_nxt = reg_wdata[10:0];
          end else begin
            err_nxt = 1'b1;
          end
        end
        OFS_STATUS: begin
          if (reg_wdata[ST_ERR]) err_nxt = 1'b0;
          if (reg_wdata[ST_STRETCH]) str_nxt = 1'b0;
        end
        OFS_COUNT: begin
          // Stored in any type, so a gated-type write takes effect later
          if (reg_wdata[19:0] != 20'h0_0000 && reg_wdata[31:20] == 12'h000 &&
              reg_wdata[19:0] <= COUNT_MAX) begin
            count_nxt = reg_wdata[19:0];
          end else begin
            err_nxt = 1'b1;
          end
        end
        OFS_PERIOD: begin
          if (reg_wdata[31:29] == 3'h0 && reg_wdata[28:0] >= PERIOD_MIN &&
              reg_wdata[28:0] <= PERIOD_MAX) begin
            period_nxt = reg_wdata[28:0];
          end else begin
            err_nxt = 1'b1;
          end
        end
        OFS_PHASE: begin
          if (ph_deg >= -PHASE_LIM && ph_deg <= PHASE_LIM) begin
            phase_nxt = ph_deg;
          end else begin
            err_nxt = 1'b1;
          end
        end
        OFS_FREQ_HI: fhi_nxt = reg_wdata[4:0];
        OFS_FREQ_LO: begin
          if (cfg_ok(shape, gated, unbounded_count, freq_cand)) begin
            freq_nxt = freq_cand;
          end else begin
            err_nxt = 1'b1;
          end
        end
        OFS_TRIG: bus_trig = 1'b1;
        default: ;
      endcase
    end
    // Hardware set beats a software clear in the same cycle
    if (str_set) str_nxt = 1'b1;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:    rdata_nxt = {21'h00_0000, ctrl_r};
        OFS_STATUS:  rdata_nxt = status_w;
        OFS_COUNT:   rdata_nxt = {12'h000, count_r};
        OFS_PERIOD:  rdata_nxt = {3'h0, period_r};
        OFS_PHASE:   rdata_nxt = {{15{phase_r[16]}}, phase_r};
        OFS_FREQ_LO: rdata_nxt = freq_r[31:0];
        OFS_FREQ_HI: rdata_nxt = {27'h000_0000, freq_r[36:32]};
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= CTRL_RST;
      count_r  <= COUNT_RST;
      period_r <= PERIOD_RST;
      phase_r  <= 17'sh0_0000;
      fhi_r    <= 5'h00;
      freq_r   <= FREQ_RST;
      err_r    <= 1'b0;
      str_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      count_r  <= count_nxt;
      period_r <= period_nxt;
      phase_r  <= phase_nxt;
      fhi_r    <= fhi_nxt;
      freq_r   <= freq_nxt;
      err_r    <= err_nxt;
      str_r    <= str_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ****************************************
  // Pin synchroniser and detection
  // ****************************************
  logic s1_r, s2_r, s3_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= trig_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic gate_act, trig_edge;
  assign gate_act  = s2_r ^ low_sense;
  assign trig_edge = slope_fall ? (s3_r & ~s2_r) : (~s3_r & s2_r);

  // ****************************************
  // Sequencer
  // ****************************************
  bwc_state_e  state_r, state_nxt;
  logic [19:0] left_r, left_nxt;
  logic [6:0]  pre_r, pre_nxt;
  logic [28:0] us_r, us_nxt;
  logic [4:0]  gap_r, gap_nxt;
  logic        load_r, load_nxt;
  logic        gap_ok, int_due, int_fire, req, start_trig;

  assign gap_ok   = gap_r >= 5'(GAP_CYC);
  assign int_due  = !gated && origin == ORIG_INT && us_r >= period_r;
  // A late burst end pushes the launch back: the period stretches itself
  assign int_fire = int_due && state_r == ST_IDLE && gap_ok;
  assign str_set  = int_due && !(state_r == ST_IDLE && gap_ok);
  // Triggers only count while idle; edges during a burst are lost
  assign req = (origin == ORIG_EXT && trig_edge) || (origin == ORIG_BUS && bus_trig) ||
               (origin == ORIG_MAN && manual_trig) || int_fire;
  assign start_trig = !gated && state_r == ST_IDLE && req;

  always_comb begin
    state_nxt = state_r;
    left_nxt  = left_r;
    load_nxt  = 1'b0;
    pre_nxt   = (pre_r == 7'(US_CYC - 1)) ? 7'h00 : pre_r + 7'h01;
    us_nxt    = (pre_r == 7'(US_CYC - 1) && us_r != PERIOD_MAX) ? us_r + 29'h1 : us_r;
    gap_nxt   = (state_r != ST_IDLE) ? 5'h00 : (gap_ok ? gap_r : gap_r + 5'h01);
    case (state_r)
      ST_IDLE: begin
        if (gated) begin
          if (gate_act) begin
            state_nxt = ST_BURST;
            load_nxt  = 1'b1;
          end
        end else if (start_trig) begin
          state_nxt = ST_BURST;
          left_nxt  = count_r;
          load_nxt  = 1'b1;
          pre_nxt   = 7'h01; // Launch cycle already counts as the first of the period
          us_nxt    = 29'h000_0000;
        end
      end
      ST_BURST: begin
        if (gated) begin
          if (!gate_act) begin
            if (shape == SHP_NOIS || cycle_end) begin
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_DRAIN;
            end
          end
        end else if (cycle_end && !unbounded_count) begin
          if (left_r <= 20'h0_0001) begin
            state_nxt = ST_IDLE;
          end else begin
            left_nxt = left_r - 20'h0_0001;
          end
        end
      end
      ST_DRAIN: begin
        if (cycle_end || shape == SHP_NOIS) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      left_r  <= 20'h0_0000;
      pre_r   <= 7'h00;
      us_r    <= 29'h000_0000;
      gap_r   <= 5'h00;
      load_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      left_r  <= left_nxt;
      pre_r   <= pre_nxt;
      us_r    <= us_nxt;
      gap_r   <= gap_nxt;
      load_r  <= load_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign status_w = {27'h000_0000, state_r == ST_IDLE && !gated, s2_r, str_r, err_r,
                     state_r != ST_IDLE};
  assign reg_rdata   = rdata_r;
  assign wave_run    = state_r != ST_IDLE;
  assign phase_load  = load_r;
  // Pulse and noise ignore phase: they always start from zero
  assign start_phase = (shape == SHP_PULS || shape == SHP_NOIS) ? 17'sh0_0000 : phase_r;
  assign wave_shape  = shape;
  assign wave_freq   = freq_r;

  // ****************************************
  // Assertions
  // ****************************************
  property p_last_cycle;
    @(posedge core_clk) disable iff (rst)
    state_r == ST_BURST && !gated && !unbounded_count && cycle_end && left_r == 20'h0_0001
    |=> state_r == ST_IDLE;
  endproperty
  a_last_cycle: assert property (p_last_cycle) else $error("burst overran its count");

  property p_gate_on;
    @(posedge core_clk) disable iff (rst)
    gated && state_r == ST_IDLE && gate_act |=> wave_run ##1 phase_load == 1'b0;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("gate did not start output");

  property p_drain;
    @(posedge core_clk) disable iff (rst)
    state_r == ST_DRAIN && !cycle_end && shape != SHP_NOIS |=> wave_run;
  endproperty
  a_drain: assert property (p_drain) else $error("cycle cut short");

  property p_noise_stop;
    @(posedge core_clk) disable iff (rst)
    gated && shape == SHP_NOIS && wave_run && !gate_act |=> !wave_run;
  endproperty
  a_noise_stop: assert property (p_noise_stop) else $error("noise not stopped");

  property p_int_only;
    @(posedge core_clk) disable iff (rst)
    int_fire |-> origin == ORIG_INT && !gated ##1 phase_load;
  endproperty
  a_int_only: assert property (p_int_only) else $error("period used wrongly");

  property p_gated_manual;
    @(posedge core_clk) disable iff (rst)
    gated && manual_trig && !reg_wr |=> !$rose(err_r);
  endproperty
  a_gated_manual: assert property (p_gated_manual) else $error("manual raised error");

  property p_count_range;
    @(posedge core_clk) disable iff (rst)
    count_r != 20'h0_0000 && count_r <= COUNT_MAX;
  endproperty
  a_count_range: assert property (p_count_range) else $error("count out of range");

  property p_freq_range;
    @(posedge core_clk) disable iff (rst)
    freq_r >= FREQ_MIN && freq_r <= FREQ_MAX && shape != SHP_DC;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("bad frequency or shape");

  property p_gap;
    @(posedge core_clk) disable iff (rst)
    $fell(wave_run) && !gated |-> !int_fire [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("burst restarted too soon");

  property p_busy_drop;
    @(posedge core_clk) disable iff (rst)
    state_r == ST_BURST && trig_edge && !gated |=> !phase_load;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("trigger taken in burst");

  property p_sync;
    @(posedge core_clk) disable iff (rst)
    s2_r == $past(trig_pin, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin not two stages");

  c_burst_done: cover property (@(posedge core_clk) disable iff (rst)
    !gated ##0 $fell(wave_run));
  c_gate_drain: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_DRAIN ##1 state_r == ST_IDLE);
  c_stretch: cover property (@(posedge core_clk) disable iff (rst) $rose(str_r));
  c_reject: cover property (@(posedge core_clk) disable iff (rst) $rose(err_r));

endmodule

`default_nettype wire

// ---- bench/bwc_far_model.sv ----
// Far-side model: trigger or gate source and synthesizer cycle marks
`timescale 1ns/1ps
`default_nettype none

module bwc_far_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       gate_mode,
  input  wire logic       gate_on,
  input  wire logic       fire,
  input  wire logic       fall_edge,
  input  wire logic [7:0] cyc_len,
  // Device side
  input  wire logic       wave_run,
  output logic            trig_pin,
  output logic            cycle_end
);
  logic [2:0] pulse_r;
  logic [2:0] pulse_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       ce_r;
  logic       ce_nxt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    pulse_nxt = (pulse_r != 3'h0) ? pulse_r - 3'h1 : 3'h0;
    if (fire) begin
      pulse_nxt = 3'h6;
    end
    cnt_nxt = 8'h00;
    ce_nxt  = 1'b0;
    // Cycle marks only while the output runs, a counter restarts each stop
    if (wave_run) begin
      cnt_nxt = cnt_r + 8'h01;
      if (cnt_nxt == cyc_len) begin
        cnt_nxt = 8'h00;
        ce_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_r <= 3'h0;
      cnt_r   <= 8'h00;
      ce_r    <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
      cnt_r   <= cnt_nxt;
      ce_r    <= ce_nxt;
    end
  end

  // Pulse of the chosen polarity, six cycles wide to survive synchronisers
  assign trig_pin  = gate_mode ? gate_on : ((pulse_r != 3'h0) ^ fall_edge);
  assign cycle_end = ce_r;
endmodule

`default_nettype wire

// ---- bench/test_bwc_core.sv ----
// Self-checking bench for the burst waveform controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end

module test_bwc_core
  import bwc_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } bwc_row_s;

  // ****************************************
  // Signals
  // ****************************************
  logic                     core_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [7:0]               reg_addr = 8'h00;
  logic [31:0]              reg_wdata = 32'h0;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [31:0]              reg_rdata;
  logic                     trig_pin;
  logic                     manual_trig = 1'b0;
  logic                     cycle_end;
  logic                     wave_run;
  logic                     phase_load;
  logic signed [16:0]       start_phase;
  logic [2:0]               wave_shape;
  logic [36:0]              wave_freq;
  logic                     gate_mode = 1'b0;
  logic                     gate_on = 1'b0;
  logic                     fire = 1'b0;
  logic                     fall_edge = 1'b0;
  logic [7:0]               cyc_len = 8'h04;
  int                       failures = 0;
  int                       checked = 0;

  localparam logic [1:0] ORIGS [3] = '{ORIG_EXT, ORIG_MAN, ORIG_BUS};
  // Reset values first, then writes with the value expected on read back
  localparam bwc_row_s ROWS [15] = '{
    '{1'b0, OFS_CTRL, 32'h0, 32'h0}, '{1'b0, OFS_COUNT, 32'h0, 32'h1},
    '{1'b0, OFS_PERIOD, 32'h0, 32'h2710}, '{1'b0, OFS_PHASE, 32'h0, 32'h0},
    '{1'b0, OFS_FREQ_LO, 32'h0, 32'h000F_4240}, '{1'b1, OFS_COUNT, 32'h5, 32'h5},
    '{1'b1, OFS_COUNT, 32'h0, 32'h5}, '{1'b1, OFS_COUNT, 32'hF_4240, 32'hF_4240},
    '{1'b1, OFS_COUNT, 32'hF_4241, 32'hF_4240}, '{1'b1, OFS_PERIOD, 32'h0, 32'h2710},
    '{1'b1, OFS_PERIOD, 32'h1DCD_6501, 32'h2710}, '{1'b1, OFS_PHASE, 32'h8CA0, 32'h8CA0},
    '{1'b1, OFS_PHASE, 32'h8CA1, 32'h8CA0}, '{1'b1, OFS_PHASE, 32'h2_03E8, 32'h1661},
    '{1'b1, 8'h20, 32'h55, 32'h0}};

  bwc_core DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_pin(trig_pin),
    .manual_trig(manual_trig), .cycle_end(cycle_end), .wave_run(wave_run),
    .phase_load(phase_load), .start_phase(start_phase), .wave_shape(wave_shape),
    .wave_freq(wave_freq));

  bwc_far_model far (.core_clk(core_clk), .rst(rst), .gate_mode(gate_mode),
    .gate_on(gate_on), .fire(fire), .fall_edge(fall_edge), .cyc_len(cyc_len),
    .wave_run(wave_run), .trig_pin(trig_pin), .cycle_end(cycle_end));

  always #5 core_clk = ~core_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic note(input string s);
    $display("Finished %s", s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // Kind 0 pin pulse, 1 panel key, 2 bus trigger write
  task automatic trig(input int k);
    @(posedge core_clk);
    if (k == 0) fire <= 1'b1;
    else if (k == 1) manual_trig <= 1'b1;
    else begin
      reg_wr   <= 1'b1;
      reg_addr <= OFS_TRIG;
    end
    @(posedge core_clk);
    fire        <= 1'b0;
    manual_trig <= 1'b0;
    reg_wr      <= 1'b0;
  endtask

  task automatic wait_run(input logic v, input int lim);
    for (int i = 0; i < lim && wave_run !== v; i++) @(negedge core_clk);
  endtask

  task automatic level(input int cyc, output int h);
    h = 0;
    repeat (cyc) begin
      @(negedge core_clk);
      if (wave_run === 1'b1) h++;
    end
  endtask

  task automatic burst(input int lim, output int n);
    n = -1;
    wait_run(1'b1, lim);
    if (wave_run !== 1'b1) return;
    `CHK(phase_load, 1'b1)
    n = 0;
    for (int i = 0; i < 5000 && wave_run === 1'b1; i++) begin
      if (cycle_end === 1'b1) n++;
      @(negedge core_clk);
    end
  endtask

  task automatic run(input int k, input int exp);
    int n;
    fork
      burst(300, n);
      trig(k);
    join
    `CHK(n, exp)
  endtask

  // Start-to-start distance of internally launched bursts
  task automatic gap(output int g);
    g = 0;
    wait_run(1'b1, 3000);
    while (wave_run === 1'b1 && g < 3000) begin
      @(negedge core_clk);
      g++;
    end
    while (wave_run !== 1'b1 && g < 3000) begin
      @(negedge core_clk);
      g++;
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin : watchdog
    repeat (60000) @(posedge core_clk);
    failures++;
    $display("Watchdog expired");
    summarize();
  end

  initial begin
    logic [31:0] d;
    logic        p;
    int          n;
    int          g;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK(wave_run, 1'b0)
    `CHK(wave_freq, 37'h0_000F_4240)
    `CHK(start_phase, 17'sh0_0000)
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, d);
      `CHK(d, ROWS[i].e)
    end
    note("registers");
    wr(OFS_STATUS, 32'h6);
    wr(OFS_COUNT, 32'h6);
    wr(OFS_PERIOD, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL, {29'h0, ORIGS[k], 1'b0});
      run(k, 6);
      level(250, n);
      `CHK(n, 0)
    end
    wr(OFS_CTRL, 32'h2);
    fork
      burst(300, n);
      begin
        trig(0);
        repeat (10) @(posedge core_clk);
        trig(0);
      end
    join
    `CHK(n, 6)
    level(100, n);
    `CHK(n, 0)
    wr(OFS_CTRL, 32'h12);
    fall_edge <= 1'b1;
    level(20, n);
    `CHK(n, 0)
    run(0, 6);
    wr(OFS_CTRL, 32'h2);
    fall_edge <= 1'b0;
    note("triggered");
    wr(OFS_CTRL, 32'h1);
    gate_mode <= 1'b1;
    wr(OFS_COUNT, 32'h2);
    gate_on <= 1'b1;
    wait_run(1'b1, 10);
    level(40, n);
    `CHK(n, 40)
    `CHK(start_phase, 17'sh0_1661)
    @(posedge core_clk);
    gate_on <= 1'b0;
    p = 1'b0;
    for (g = 0; g < 30 && wave_run === 1'b1; g++) begin
      p = cycle_end;
      @(negedge core_clk);
    end
    `CHK(p, 1'b1)
    trig(1);
    level(40, n);
    `CHK(n, 0)
    rd(OFS_STATUS, d);
    `CHK(d[ST_ERR], 1'b0)
    rd(OFS_COUNT, d);
    `CHK(d, 32'h2)
    wr(OFS_CTRL, 32'h9);
    wait_run(1'b1, 10);
    `CHK(wave_run, 1'b1)
    @(posedge core_clk);
    gate_on <= 1'b1;
    wait_run(1'b0, 30);
    `CHK(wave_run, 1'b0)
    // Slow cycles so that only an immediate stop can pass
    cyc_len <= 8'hC8;
    wr(OFS_CTRL, 32'h501);
    wait_run(1'b1, 10);
    `CHK(wave_shape, SHP_NOIS)
    `CHK(start_phase, 17'sh0_0000)
    repeat (20) @(posedge core_clk);
    gate_on <= 1'b0;
    wait_run(1'b0, 6);
    `CHK(wave_run, 1'b0)
    cyc_len <= 8'h04;
    wr(OFS_CTRL, 32'h601);
    wr(OFS_CTRL, 32'h500);
    rd(OFS_CTRL, d);
    `CHK(d, 32'h501)
    rd(OFS_STATUS, d);
    `CHK(d[ST_ERR], 1'b1)
    note("gated");
    gate_mode <= 1'b0;
    wr(OFS_CTRL, 32'h2);
    run(0, 2);
    wr(OFS_CTRL, 32'h0);
    gap(g);
    `CHK(g, 200)
    wr(OFS_COUNT, 32'h3C);
    gap(g);
    gap(g);
    `CHK(g inside {[258:300]}, 1'b1)
    rd(OFS_STATUS, d);
    `CHK(d[ST_STRETCH], 1'b1)
    note("internal");
    // Above 25 MHz a sine needs the unbounded count
    wr(OFS_CTRL, 32'h2);
    wait_run(1'b0, 300);
    wr(OFS_STATUS, 32'h6);
    wr(OFS_FREQ_HI, 32'h6);
    wr(OFS_FREQ_LO, 32'hFC23_AC00);
    rd(OFS_STATUS, d);
    `CHK(d[ST_ERR], 1'b1)
    `CHK(wave_freq, 37'h0_000F_4240)
    wr(OFS_CTRL, 32'h22);
    wr(OFS_FREQ_LO, 32'hFC23_AC00);
    @(negedge core_clk);
    `CHK(wave_freq, 37'h6_FC23_AC00)
    trig(0);
    wait_run(1'b1, 10);
    level(300, n);
    `CHK(n, 300)
    note("unbounded");
    summarize();
  end
endmodule

`default_nettype wire
